// *** src/mcu_io_ports.sv ***
`include "io_ports_params.svh"

module mcu_io_ports
	import io_ports_pkg::*;
#(
	parameter int STATE_DIV    = `STATE_DIV_CYC,
	parameter int STROBE_STATE = `STROBE_STATES
) (
	// Clock and reset.
	input  wire logic           i_sys_clk,
	input  wire logic           i_rst_n,
	// Core command port.
	input  wire logic           i_cmd_valid,
	input  wire port_cmd_type   i_cmd,
	output logic                o_cmd_done,
	output logic [7:0]          o_rd_data,
	// Quasi-bidirectional port pins.
	input  wire logic [7:0]     i_p1_pin,
	input  wire logic [7:0]     i_p2_pin,
	output quasi_pins_type      o_p1,
	output quasi_pins_type      o_p2,
	// Data bus and strobes.
	input  wire logic [7:0]     i_bus_pin,
	output logic [7:0]          o_bus_data,
	output logic [7:0]          o_bus_oe,
	output logic                o_rd_n,
	output logic                o_wr_n
);

	// Three-flop input synchronisers; a change counts once stages two and three agree.
	logic [7:0] p1_s1, p1_s2, p1_s3, p1_live;
	logic [7:0] p2_s1, p2_s2, p2_s3, p2_live;
	logic [7:0] bus_s1, bus_s2, bus_s3, bus_live;
	logic [7:0] next_p1_live, next_p2_live, next_bus_live;

	always_comb begin
		next_p1_live  = (p1_s2 == p1_s3) ? p1_s3 : p1_live;
		next_p2_live  = (p2_s2 == p2_s3) ? p2_s3 : p2_live;
		next_bus_live = (bus_s2 == bus_s3) ? bus_s3 : bus_live;
	end

	always_ff @(posedge i_sys_clk) begin
		p1_s1    <= i_p1_pin;
		p1_s2    <= p1_s1;
		p1_s3    <= p1_s2;
		p2_s1    <= i_p2_pin;
		p2_s2    <= p2_s1;
		p2_s3    <= p2_s2;
		bus_s1   <= i_bus_pin;
		bus_s2   <= bus_s1;
		bus_s3   <= bus_s2;
		p1_live  <= next_p1_live;
		p2_live  <= next_p2_live;
		bus_live <= next_bus_live;
	end

	// State clock enable, one pulse per state.
	logic [15:0] div_cnt, next_div_cnt;
	logic        state_tick, next_state_tick;

	always_comb begin
		next_state_tick = 1'b0;
		next_div_cnt    = div_cnt + 16'h0001;
		if (div_cnt == 16'(STATE_DIV * `OSC_DIV - 1)) begin
			next_div_cnt    = 16'h0000;
			next_state_tick = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			div_cnt    <= 16'h0000;
			state_tick <= 1'b0;
		end else begin
			div_cnt    <= next_div_cnt;
			state_tick <= next_state_tick;
		end
	end

	// Quasi port latches and strong pull-up pulses.
	logic [7:0] p1_latch, p2_latch, next_p1_latch, next_p2_latch;
	logic [7:0] p1_pu, p2_pu, next_p1_pu, next_p2_pu;
	logic [1:0] pu_age, next_pu_age;
	logic       quasi_cmd;
	logic [7:0] cur_latch, cur_live, new_val;

	always_comb begin
		quasi_cmd = i_cmd_valid && (i_cmd.op inside {OP_PORT_WRITE, OP_PORT_AND, OP_PORT_OR});
		cur_latch = i_cmd.port_sel ? p2_latch : p1_latch;
		cur_live  = i_cmd.port_sel ? p2_live : p1_live;
		case (i_cmd.op)
			OP_PORT_AND: new_val = cur_live & i_cmd.operand;
			OP_PORT_OR:  new_val = cur_live | i_cmd.operand;
			default:     new_val = i_cmd.operand;
		endcase
		next_p1_latch = p1_latch;
		next_p2_latch = p2_latch;
		next_p1_pu    = p1_pu;
		next_p2_pu    = p2_pu;
		next_pu_age   = pu_age;
		// The pulse spans the rest of this state and one full state after it.
		if (state_tick && pu_age != 2'd0) begin
			next_pu_age = pu_age - 2'd1;
			if (pu_age == 2'd1) begin
				next_p1_pu = 8'h00;
				next_p2_pu = 8'h00;
			end
		end
		if (quasi_cmd) begin
			// Each bit is its own latch, so pins mix input and output freely.
			// A bit written low drops its pull-up at once, so it never fights the low drive.
			if (i_cmd.port_sel) begin
				next_p2_latch = new_val;
				next_p2_pu    = (next_p2_pu & new_val) | (new_val & ~p2_latch);
			end else begin
				next_p1_latch = new_val;
				next_p1_pu    = (next_p1_pu & new_val) | (new_val & ~p1_latch);
			end
			if ((new_val & ~cur_latch) != 8'h00) begin
				next_pu_age = 2'd2;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			p1_latch <= `PORT_LATCH_RESET;
			p2_latch <= `PORT_LATCH_RESET;
			p1_pu    <= 8'h00;
			p2_pu    <= 8'h00;
			pu_age   <= 2'd0;
		end else begin
			p1_latch <= next_p1_latch;
			p2_latch <= next_p2_latch;
			p1_pu    <= next_p1_pu;
			p2_pu    <= next_p2_pu;
			pu_age   <= next_pu_age;
		end
	end

	// Data bus sequencer.
	bus_state_type bus_state, next_bus_state;
	logic [7:0]    bus_latch, next_bus_latch;
	logic [3:0]    bus_cnt, next_bus_cnt;
	logic          done, next_done;
	logic [7:0]    rd_data, next_rd_data;
	logic          bus_cmd;

	always_comb begin
		bus_cmd        = i_cmd_valid && (i_cmd.op inside {OP_STATIC_BUS_WRITE,
			OP_STATIC_BUS_READ, OP_EXT_DATA_MOVE});
		next_bus_state = bus_state;
		next_bus_latch = bus_latch;
		next_bus_cnt   = bus_cnt;
		next_done      = 1'b0;
		next_rd_data   = rd_data;
		case (bus_state)
			BUS_IDLE: begin
				if (i_cmd_valid && i_cmd.op == OP_PORT_READ) begin
					next_rd_data = i_cmd.port_sel ? p2_live : p1_live;
					next_done    = 1'b1;
				end else if (quasi_cmd) begin
					next_done = 1'b1;
				end else if (bus_cmd) begin
					next_bus_cnt = 4'(STROBE_STATE);
					if (i_cmd.op == OP_STATIC_BUS_WRITE ||
						(i_cmd.op == OP_EXT_DATA_MOVE && i_cmd.move_write)) begin
						next_bus_latch = i_cmd.operand;
						next_bus_state = BUS_WRITE;
					end else begin
						next_bus_state = BUS_READ;
					end
				end
			end
			BUS_WRITE, BUS_READ: begin
				if (state_tick) begin
					next_bus_cnt = bus_cnt - 4'd1;
					if (bus_cnt == 4'd1) begin
						// Sample in the last cycle the read strobe is still low.
						if (bus_state == BUS_READ) begin
							next_rd_data = bus_live;
						end
						next_done      = 1'b1;
						next_bus_state = BUS_IDLE;
					end
				end
			end
			default: next_bus_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			bus_state <= BUS_IDLE;
			bus_latch <= 8'h00;
			bus_cnt   <= 4'h0;
			done      <= 1'b0;
			rd_data   <= 8'h00;
		end else begin
			bus_state <= next_bus_state;
			bus_latch <= next_bus_latch;
			bus_cnt   <= next_bus_cnt;
			done      <= next_done;
			rd_data   <= next_rd_data;
		end
	end

	// Registered pin outputs.
	logic          next_rd_n, next_wr_n;
	logic [7:0]    next_bus_oe;
	quasi_pins_type next_p1, next_p2;

	always_comb begin
		// All bus pins share one enable and float outside a write.
		next_bus_oe = (next_bus_state == BUS_WRITE) ? 8'hFF : 8'h00;
		next_wr_n   = (next_bus_state != BUS_WRITE);
		next_rd_n   = (next_bus_state != BUS_READ);
		// A one is left to the weak pull-up; only zeros are driven.
		next_p1.data_out  = next_p1_latch;
		next_p1.data_oe   = ~next_p1_latch;
		next_p1.strong_pu = next_p1_pu;
		next_p2.data_out  = next_p2_latch;
		next_p2.data_oe   = ~next_p2_latch;
		next_p2.strong_pu = next_p2_pu;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_bus_oe   <= 8'h00;
			o_bus_data <= 8'h00;
			o_wr_n     <= 1'b1;
			o_rd_n     <= 1'b1;
			o_p1       <= '{data_out: `PORT_LATCH_RESET, data_oe: 8'h00, strong_pu: 8'h00};
			o_p2       <= '{data_out: `PORT_LATCH_RESET, data_oe: 8'h00, strong_pu: 8'h00};
			o_cmd_done <= 1'b0;
			o_rd_data  <= 8'h00;
		end else begin
			o_bus_oe   <= next_bus_oe;
			o_bus_data <= next_bus_latch;
			o_wr_n     <= next_wr_n;
			o_rd_n     <= next_rd_n;
			o_p1       <= next_p1;
			o_p2       <= next_p2;
			o_cmd_done <= next_done;
			o_rd_data  <= next_rd_data;
		end
	end

endmodule

// *** src/io_ports_params.svh ***
`ifndef IO_PORTS_PARAMS_SVH
`define IO_PORTS_PARAMS_SVH

// Oscillator and state timing.
`define OSC_DIV           3
`define STRONG_PULLUP_NS  500
`define SYS_CLK_PERIOD_NS 10
`define STRONG_PULLUP_CYC ((`STRONG_PULLUP_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define STATE_DIV_CYC     (`STRONG_PULLUP_CYC / `OSC_DIV)
// Strobe length in states and reset value of the quasi port latches.
`define STROBE_STATES     3
`define PORT_LATCH_RESET  8'hFF

`endif

// *** src/io_ports_pkg.sv ***
package io_ports_pkg;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_PORT_WRITE,
		OP_PORT_AND,
		OP_PORT_OR,
		OP_PORT_READ,
		OP_STATIC_BUS_WRITE,
		OP_STATIC_BUS_READ,
		OP_EXT_DATA_MOVE
	} port_op_type;

	typedef struct packed {
		port_op_type op;
		logic        port_sel;
		logic        move_write;
		logic [7:0]  operand;
	} port_cmd_type;

	typedef struct packed {
		logic [7:0] data_out;
		logic [7:0] data_oe;
		logic [7:0] strong_pu;
	} quasi_pins_type;

	typedef enum {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ
	} bus_state_type;

endpackage

// *** sim/io_ports_asserts.sv ***
module io_ports_asserts
	import io_ports_pkg::*;
(
	input wire logic           i_sys_clk,
	input wire logic           i_rst_n,
	input wire logic           i_cmd_valid,
	input wire port_cmd_type   i_cmd,
	input wire logic           o_cmd_done,
	input wire quasi_pins_type o_p1,
	input wire logic [7:0]     o_bus_data,
	input wire logic [7:0]     o_bus_oe,
	input wire logic           o_rd_n,
	input wire logic           o_wr_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	chk_bus_dir: assert property (o_bus_oe == 8'h00 || o_bus_oe == 8'hFF)
		else $error("bus pins split direction");
	chk_bus_float: assert property (o_bus_oe != 8'h00 |-> !o_wr_n)
		else $error("bus driven outside a write");
	chk_strobe_excl: assert property (o_rd_n || o_wr_n)
		else $error("both strobes low");
	chk_latch_hold: assert property (!i_cmd_valid |=> $stable(o_p1.data_out))
		else $error("port latch changed without a command");
	chk_pu_rise: assert property ($rose(o_p1.strong_pu[0]) |-> $rose(o_p1.data_out[0]))
		else $error("strong pull-up without a rising write");
	chk_pu_short: assert property (o_p1.strong_pu[0] |-> ##[1:200] !o_p1.strong_pu[0])
		else $error("strong pull-up too long");
	chk_wr_done: assert property ($rose(o_wr_n) |-> o_cmd_done)
		else $error("write strobe ended without done");
	chk_rd_start: assert property (i_cmd_valid && i_cmd.op == OP_STATIC_BUS_READ
		&& o_rd_n && o_wr_n |=> !o_rd_n)
		else $error("read strobe not started");
	chk_wr_data: assert property (!o_wr_n && !$past(o_wr_n) |-> $stable(o_bus_data))
		else $error("bus data moved during write strobe");
endmodule

bind mcu_io_ports io_ports_asserts i_chk (
	.i_sys_clk  (i_sys_clk),
	.i_rst_n    (i_rst_n),
	.i_cmd_valid(i_cmd_valid),
	.i_cmd      (i_cmd),
	.o_cmd_done (o_cmd_done),
	.o_p1       (o_p1),
	.o_bus_data (o_bus_data),
	.o_bus_oe   (o_bus_oe),
	.o_rd_n     (o_rd_n),
	.o_wr_n     (o_wr_n)
);

// *** sim/io_ports_far.sv ***
module io_ports_far
	import io_ports_pkg::*;
(
	input  wire quasi_pins_type i_p1,
	input  wire quasi_pins_type i_p2,
	input  wire logic [7:0]     i_ext1,
	input  wire logic [7:0]     i_ext2,
	input  wire logic [7:0]     i_ext_bus,
	input  wire logic [7:0]     i_bus_data,
	input  wire logic [7:0]     i_bus_oe,
	input  wire logic           i_rd_n,
	output logic [7:0]          o_p1_pin,
	output logic [7:0]          o_p2_pin,
	output logic [7:0]          o_bus_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outside port drivers only pull low, i_ext_bus drives the bus during a read; released lines rest at the pull-up level.
	assign o_p1_pin = ~i_p1.data_oe & i_ext1;
	assign o_p2_pin = ~i_p2.data_oe & i_ext2;
	assign o_bus_pin = |i_bus_oe ? i_bus_data : (!i_rd_n ? i_ext_bus : 8'hFF);
endmodule

// *** sim/test_mcu_io_ports.sv ***
module test_mcu_io_ports;
	timeunit 1ns;
	timeprecision 1ps;
	import io_ports_pkg::*;
	logic           clk = 0, rst_n = 0, valid = 0, done, rd_n, wr_n;
	port_cmd_type   cmd = '0;
	quasi_pins_type p1, p2;
	logic [7:0]     e1 = 8'hFF, e2 = 8'hFF, eb = 8'h00, p1_pin, p2_pin, bus_pin;
	logic [7:0]     rd_data, bus_data, bus_oe, l1 = 8'hFF, l2 = 8'hFF, rd = 8'h00, bd = 8'h00;
	logic [47:0]    notes[$], note;
	int             fail_count = 0, n_tests = 0;

	initial forever #5 clk = ~clk;
	mcu_io_ports #(.STATE_DIV(2), .STROBE_STATE(2)) i_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_cmd_valid(valid), .i_cmd(cmd), .o_cmd_done(done), .o_rd_data(rd_data),
		.i_p1_pin(p1_pin), .i_p2_pin(p2_pin), .o_p1(p1), .o_p2(p2), .i_bus_pin(bus_pin),
		.o_bus_data(bus_data), .o_bus_oe(bus_oe), .o_rd_n(rd_n), .o_wr_n(wr_n));
	io_ports_far i_far (.i_p1(p1), .i_p2(p2), .i_ext1(e1), .i_ext2(e2), .i_ext_bus(eb),
		.i_bus_data(bus_data), .i_bus_oe(bus_oe), .i_rd_n(rd_n), .o_p1_pin(p1_pin),
		.o_p2_pin(p2_pin), .o_bus_pin(bus_pin));

	task check(string name, logic [47:0] seen, logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task run(port_op_type op, logic sel, logic mw, logic [7:0] v);
		logic [7:0] old, nl, pn;
		int n;
		old = sel ? l2 : l1;
		pn = old & (sel ? e2 : e1);
		nl = old;
		if (op == OP_PORT_WRITE) nl = v;
		if (op == OP_PORT_AND) nl = pn & v;
		if (op == OP_PORT_OR) nl = pn | v;
		if (op == OP_PORT_READ) rd = pn;
		if (op == OP_STATIC_BUS_WRITE || op == OP_EXT_DATA_MOVE && mw) bd = v;
		if (op == OP_STATIC_BUS_READ || op == OP_EXT_DATA_MOVE && !mw) rd = eb;
		if (sel) l2 = nl;
		else l1 = nl;
		notes.push_back({l1, l2, sel ? 8'h00 : nl & ~old, sel ? nl & ~old : 8'h00, bd, rd});
		cmd = '{op, sel, mw, v};
		valid = 1;
		@(negedge clk);
		valid = 0;
		n = 0;
		while (notes.size() > 0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n == 100) fail_count++;
		repeat (15) @(negedge clk);
	endtask

	always @(negedge clk) if (done === 1'b1) begin
		if (notes.size() == 0) fail_count++;
		else begin
			note = notes.pop_front();
			check("result", {p1.data_out, p2.data_out, p1.strong_pu, p2.strong_pu, bus_data,
				rd_data}, note);
			check("drive", {p1.data_oe, p2.data_oe}, {~note[47:32]});
		end
	end

	initial begin
		void'($urandom(17150));
		repeat (2) @(negedge clk);
		rst_n = 1;
		check("reset", {p1.data_out, p2.data_out, p1.data_oe, bus_oe, 6'h00, rd_n, wr_n},
			{24'hFFFF00, 8'h00, 8'h03});
		for (int i = 0; i < 42; i++) begin
			e1 = 8'($urandom);
			e2 = 8'($urandom);
			eb = 8'($urandom);
			repeat (5) @(negedge clk);
			run(port_op_type'(1 + i % 7), 1'($urandom), 1'($urandom), 8'($urandom));
		end
		// Release every pin of port 1 before it is read back as an input.
		run(OP_PORT_WRITE, 1'b0, 1'b0, 8'hFF);
		run(OP_PORT_READ, 1'b0, 1'b0, 8'h00);
		conclude;
	end

	initial begin
		#100000;
		fail_count++;
		conclude;
	end
endmodule
